/* File: common/rsl_pkg.sv */
// constants, types and encodings of the processor reset source logic
// Function
// - main reset on power-up or reset pin held low more than 4 cycles
// - power-on and pin resets run the same initialisation and start sequence
// - watchdog or clock failure drives the shared line low under 4 cycles
// - internal reset records watchdog or clock monitor and fetches its vector
// - power-on and pin resets fetch their start address from FFFE
// - watchdog and clock-failure vectors differ from the power-on vector
// - every hardware reset clears control registers 8000H-805FH before vector fetch
// - illegal opcode traps to a restart vector without a hardware reset
// - clock monitor forces full reset when the system clock stops
// - enabled watchdog resets when software misses its service in time
// - active-low external interrupt input requests immediate service
// - stop and wait instructions enter two low-power depths
// - two-bit select picks 8.192, 32.768, 131.07 or 524.5 ms timeout
// - timeout select writable only in first 64 cycles after reset
package rsl_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [2:0] EXT_LOW_MIN_CYC = 3'h4;
    localparam logic [1:0] DRV_CYC = 2'h3;
    localparam int CLKMON_TMO_NS = 200;
    localparam logic [4:0] CLKMON_CYC = 5'(CLKMON_TMO_NS / CLK_PERIOD_NS);
    localparam logic [6:0] SEL_WIN_CYC = 7'h40;
    localparam real WD_T0_MS = 8.192;
    localparam real WD_T1_MS = 32.768;
    localparam real WD_T2_MS = 131.07;
    localparam real WD_T3_MS = 524.5;
    localparam int WD_CYC0 = int'(WD_T0_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int WD_CYC1 = int'(WD_T1_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int WD_CYC2 = int'(WD_T2_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int WD_CYC3 = int'(WD_T3_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int WD_W = 26;

    // ----------------------------------------------------------------
    // addresses, patterns and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] REG_BASE = 16'h8000;
    localparam logic [15:0] REG_LAST = 16'h805f;
    localparam logic [15:0] VEC_POR = 16'hfffe;
    localparam logic [7:0] SVC_KEY0 = 8'h55;
    localparam logic [7:0] SVC_KEY1 = 8'haa;
    localparam logic [1:0] SEL_RST = 2'h0;

    typedef enum logic [1:0] {
        CAUSE_EXT    = 2'h0,
        CAUSE_WDOG   = 2'h1,
        CAUSE_CLKMON = 2'h2,
        CAUSE_TRAP   = 2'h3
    } rsl_cause_t;

    typedef enum logic [6:0] {
        ST_INIT  = 7'h01,
        ST_VEC   = 7'h02,
        ST_RUN   = 7'h04,
        ST_WAIT  = 7'h08,
        ST_STOP  = 7'h10,
        ST_DRIVE = 7'h20,
        ST_HOLD  = 7'h40
    } rsl_state_t;

endpackage

/* File: common/rsl_evt_if.sv */
// links between the sequencer, the reset pin filter and the watchdog
`timescale 1ns/1ps
`default_nettype none
interface rsl_evt_if;
    logic       ext_rst;
    logic       wd_run;
    logic       wd_clr;
    logic [1:0] wd_sel;
    logic       wd_svc_wr;
    logic [7:0] wd_svc_data;
    logic       wd_tmo;

    modport ctl  (input ext_rst, wd_tmo, output wd_run, wd_clr, wd_sel, wd_svc_wr, wd_svc_data);
    modport filt (output ext_rst);
    modport wdog (input wd_run, wd_clr, wd_sel, wd_svc_wr, wd_svc_data, output wd_tmo);
endinterface
`default_nettype wire

/* File: design/rsl_pin_filter.sv */
// synchroniser and low-time qualifier for the shared reset line
`timescale 1ns/1ps
`default_nettype none
module rsl_pin_filter (
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    input  wire logic rst_line_n_i,
    rsl_evt_if.filt   evt
);
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic [2:0] low_cnt;
        logic       ext;
    } rsl_filt_t;

    rsl_filt_t st_r;
    rsl_filt_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = rst_line_n_i;
        st_nxt.s2 = st_r.s1;
        // only the second stage is looked at, so a release can't split
        if (st_r.s2) begin
            st_nxt.low_cnt = 3'h0;
            st_nxt.ext = 1'b0;
        end else if (st_r.low_cnt == rsl_pkg::EXT_LOW_MIN_CYC) begin
            st_nxt.ext = 1'b1;
        end else begin
            st_nxt.low_cnt = st_r.low_cnt + 3'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, low_cnt: 3'h0, ext: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt.ext_rst = st_r.ext;

    a_low_qualify: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (!st_r.s2) [*5] |=> st_r.ext) else $error("five low cycles did not raise reset");
endmodule // rsl_pin_filter
`default_nettype wire

/* File: design/rsl_watchdog.sv */
// operating watchdog: period select, two-key service and timeout
`timescale 1ns/1ps
`default_nettype none
module rsl_watchdog #(
    parameter int P0 = rsl_pkg::WD_CYC0,
    parameter int P1 = rsl_pkg::WD_CYC1,
    parameter int P2 = rsl_pkg::WD_CYC2,
    parameter int P3 = rsl_pkg::WD_CYC3
) (
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    rsl_evt_if.wdog   evt
);
    typedef struct packed {
        logic [rsl_pkg::WD_W-1:0] cnt;
        logic                     armed;
        logic                     tmo;
    } rsl_wd_t;

    rsl_wd_t st_r;
    rsl_wd_t st_nxt;

    function automatic logic [rsl_pkg::WD_W-1:0] limit(input logic [1:0] sel);
        case (sel)
            2'h0:    limit = rsl_pkg::WD_W'(P0 - 1);
            2'h1:    limit = rsl_pkg::WD_W'(P1 - 1);
            2'h2:    limit = rsl_pkg::WD_W'(P2 - 1);
            default: limit = rsl_pkg::WD_W'(P3 - 1);
        endcase
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.tmo = 1'b0;
        if (evt.wd_clr) begin
            st_nxt.cnt = '0;
            st_nxt.armed = 1'b0;
        end else if (evt.wd_run) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (evt.wd_svc_wr) begin
                st_nxt.armed = (evt.wd_svc_data == rsl_pkg::SVC_KEY0);
                if (st_r.armed && evt.wd_svc_data == rsl_pkg::SVC_KEY1) begin
                    st_nxt.cnt = '0;
                end
            end
            if (st_r.cnt >= limit(evt.wd_sel)) begin
                st_nxt.cnt = '0;
                st_nxt.tmo = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            st_r <= '{cnt: '0, armed: 1'b0, tmo: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt.wd_tmo = st_r.tmo;

    a_wd_expiry: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        evt.wd_run && !evt.wd_clr && st_r.cnt == limit(evt.wd_sel) |=> st_r.tmo && st_r.cnt == '0)
        else $error("watchdog missed its timeout");
endmodule // rsl_watchdog
`default_nettype wire

/* File: design/rsl_top.sv */
// reset source sequencer: pin, power-on, watchdog, clock monitor, trap
`timescale 1ns/1ps
`default_nettype none
module rsl_top #(
    parameter int          WD_CYC0    = rsl_pkg::WD_CYC0,
    parameter int          WD_CYC1    = rsl_pkg::WD_CYC1,
    parameter int          WD_CYC2    = rsl_pkg::WD_CYC2,
    parameter int          WD_CYC3    = rsl_pkg::WD_CYC3,
    parameter logic [15:0] VEC_WDOG   = 16'he000,
    parameter logic [15:0] VEC_CLKMON = 16'he004,
    parameter logic [15:0] VEC_TRAP   = 16'he008
) (
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    input  wire logic        rst_line_n_i,
    output logic             rst_line_o,
    output logic             rst_line_oe_o,
    input  wire logic        wdog_en_i,
    input  wire logic        sel_wr_i,
    input  wire logic        watchdog_period_select_hi_i,
    input  wire logic        watchdog_period_select_lo_i,
    input  wire logic        watchdog_service_register_wr_i,
    input  wire logic [7:0]  watchdog_service_register_data_i,
    input  wire logic        clkmon_en_i,
    input  wire logic        clk_alive_i,
    input  wire logic        irq_n_i,
    input  wire logic        ill_op_i,
    input  wire logic        wait_for_interrupt_instruction_i,
    input  wire logic        stop_insn_i,
    output logic             ctrl_init_we_o,
    output logic [15:0]      ctrl_init_addr_o,
    output logic             vec_fetch_o,
    output logic [15:0]      vec_addr_o,
    output logic [1:0]       cause_o,
    output logic             cpu_run_o,
    output logic             lp_wait_o,
    output logic             lp_stop_o,
    output logic             irq_req_o,
    output logic [1:0]       wd_sel_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        rsl_pkg::rsl_state_t state;
        rsl_pkg::rsl_cause_t cause;
        logic [1:0]          drv_cnt;
        logic                line_oe;
        logic                init_we;
        logic [15:0]         init_adr;
        logic                vec_fetch;
        logic [15:0]         vec_adr;
        logic [1:0]          sel;
        logic [6:0]          win_cnt;
        logic                alive_q;
        logic [4:0]          mon_cnt;
        logic                clk_fail;
        logic                irq_q;
        logic                run;
        logic                lp_wait;
        logic                lp_stop;
    } rsl_top_t;

    rsl_top_t  st_r;
    rsl_top_t  st_nxt;
    rsl_evt_if evt ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] vec_of(input rsl_pkg::rsl_cause_t c);
        case (c)
            rsl_pkg::CAUSE_WDOG:   vec_of = VEC_WDOG;
            rsl_pkg::CAUSE_CLKMON: vec_of = VEC_CLKMON;
            rsl_pkg::CAUSE_TRAP:   vec_of = VEC_TRAP;
            default:               vec_of = rsl_pkg::VEC_POR;
        endcase
    endfunction

    function automatic logic active(input rsl_pkg::rsl_state_t s);
        active = (s == rsl_pkg::ST_RUN) || (s == rsl_pkg::ST_WAIT) || (s == rsl_pkg::ST_STOP);
    endfunction

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    rsl_pin_filter u_filt (
        .sys_clk_i    (sys_clk_i),
        .srst_i       (srst_i),
        .rst_line_n_i (rst_line_n_i),
        .evt          (evt.filt)
    );

    rsl_watchdog #(
        .P0 (WD_CYC0),
        .P1 (WD_CYC1),
        .P2 (WD_CYC2),
        .P3 (WD_CYC3)
    ) u_wdog (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .evt       (evt.wdog)
    );

    // stop freezes the watchdog, wait lets it run on
    assign evt.wd_run      = wdog_en_i && (st_r.state == rsl_pkg::ST_RUN || st_r.state == rsl_pkg::ST_WAIT);
    assign evt.wd_clr      = !active(st_r.state);
    assign evt.wd_sel      = st_r.sel;
    assign evt.wd_svc_wr   = watchdog_service_register_wr_i && st_r.state == rsl_pkg::ST_RUN;
    assign evt.wd_svc_data = watchdog_service_register_data_i;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.init_we = 1'b0;
        st_nxt.vec_fetch = 1'b0;
        st_nxt.clk_fail = 1'b0;
        st_nxt.irq_q = !irq_n_i;
        st_nxt.alive_q = clk_alive_i;

        // clock monitor: no edge on the alive sense for too long means a dead clock
        if (!clkmon_en_i || !active(st_r.state) || st_r.state == rsl_pkg::ST_STOP
            || clk_alive_i != st_r.alive_q) begin
            st_nxt.mon_cnt = 5'h0;
        end else if (st_r.mon_cnt == rsl_pkg::CLKMON_CYC - 5'h1) begin
            st_nxt.mon_cnt = 5'h0;
            st_nxt.clk_fail = 1'b1;
        end else begin
            st_nxt.mon_cnt = st_r.mon_cnt + 5'h1;
        end

        if (st_r.state == rsl_pkg::ST_RUN && st_r.win_cnt != rsl_pkg::SEL_WIN_CYC) begin
            st_nxt.win_cnt = st_r.win_cnt + 7'h1;
            if (sel_wr_i) begin
                st_nxt.sel = {watchdog_period_select_hi_i, watchdog_period_select_lo_i};
            end
        end

        case (st_r.state)
            rsl_pkg::ST_INIT: begin
                // walk the whole control block before any fetch happens
                st_nxt.init_we = 1'b1;
                st_nxt.init_adr = st_r.init_we ? st_r.init_adr + 16'h1 : rsl_pkg::REG_BASE;
                st_nxt.sel = rsl_pkg::SEL_RST;
                if (st_r.init_we && st_r.init_adr == rsl_pkg::REG_LAST - 16'h1) begin
                    st_nxt.state = rsl_pkg::ST_VEC;
                end
            end
            rsl_pkg::ST_VEC: begin
                st_nxt.vec_fetch = 1'b1;
                st_nxt.vec_adr = vec_of(st_r.cause);
                st_nxt.state = rsl_pkg::ST_RUN;
                if (st_r.cause != rsl_pkg::CAUSE_TRAP) begin
                    st_nxt.win_cnt = 7'h0;
                end
            end
            rsl_pkg::ST_RUN: begin
                if (ill_op_i) begin
                    st_nxt.cause = rsl_pkg::CAUSE_TRAP;
                    st_nxt.state = rsl_pkg::ST_VEC;
                end else if (stop_insn_i) begin
                    st_nxt.state = rsl_pkg::ST_STOP;
                end else if (wait_for_interrupt_instruction_i) begin
                    st_nxt.state = rsl_pkg::ST_WAIT;
                end
            end
            rsl_pkg::ST_WAIT, rsl_pkg::ST_STOP: begin
                if (st_r.irq_q) begin
                    st_nxt.state = rsl_pkg::ST_RUN;
                end
            end
            rsl_pkg::ST_DRIVE: begin
                // short pulse so our own drive never qualifies as a pin reset
                if (st_r.drv_cnt == rsl_pkg::DRV_CYC - 2'h1) begin
                    st_nxt.line_oe = 1'b0;
                    st_nxt.state = rsl_pkg::ST_INIT;
                end else begin
                    st_nxt.drv_cnt = st_r.drv_cnt + 2'h1;
                end
            end
            rsl_pkg::ST_HOLD: begin
                if (!evt.ext_rst) begin
                    st_nxt.state = rsl_pkg::ST_INIT;
                end
            end
            default: begin
                st_nxt.state = rsl_pkg::ST_INIT;
            end
        endcase

        // clock failure ranks above the watchdog when both fire together
        if (active(st_r.state) && (st_r.clk_fail || evt.wd_tmo)) begin
            st_nxt.cause = st_r.clk_fail ? rsl_pkg::CAUSE_CLKMON : rsl_pkg::CAUSE_WDOG;
            st_nxt.state = rsl_pkg::ST_DRIVE;
            st_nxt.drv_cnt = 2'h0;
            st_nxt.line_oe = 1'b1;
            st_nxt.vec_fetch = 1'b0;
        end

        if (evt.ext_rst && st_r.state != rsl_pkg::ST_DRIVE) begin
            st_nxt.state = rsl_pkg::ST_HOLD;
            st_nxt.cause = rsl_pkg::CAUSE_EXT;
            st_nxt.line_oe = 1'b0;
            st_nxt.init_we = 1'b0;
            st_nxt.vec_fetch = 1'b0;
        end

        // state levels are registered so the core sees clean flop outputs
        st_nxt.run = st_nxt.state == rsl_pkg::ST_RUN;
        st_nxt.lp_wait = st_nxt.state == rsl_pkg::ST_WAIT;
        st_nxt.lp_stop = st_nxt.state == rsl_pkg::ST_STOP;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // power-up enters the same sequence as a pin reset
            st_r <= '{state: rsl_pkg::ST_INIT, cause: rsl_pkg::CAUSE_EXT, drv_cnt: 2'h0,
                      line_oe: 1'b0, init_we: 1'b0, init_adr: rsl_pkg::REG_BASE,
                      vec_fetch: 1'b0, vec_adr: rsl_pkg::VEC_POR, sel: rsl_pkg::SEL_RST,
                      win_cnt: rsl_pkg::SEL_WIN_CYC, alive_q: 1'b0, mon_cnt: 5'h0,
                      clk_fail: 1'b0, irq_q: 1'b0, run: 1'b0, lp_wait: 1'b0,
                      lp_stop: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rst_line_o       = 1'b0 & st_r.line_oe;
    assign rst_line_oe_o    = st_r.line_oe;
    assign ctrl_init_we_o   = st_r.init_we;
    assign ctrl_init_addr_o = st_r.init_adr;
    assign vec_fetch_o      = st_r.vec_fetch;
    assign vec_addr_o       = st_r.vec_adr;
    assign cause_o          = st_r.cause;
    assign cpu_run_o        = st_r.run;
    assign lp_wait_o        = st_r.lp_wait;
    assign lp_stop_o        = st_r.lp_stop;
    assign irq_req_o        = st_r.irq_q;
    assign wd_sel_o         = st_r.sel;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_drive_short: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $rose(rst_line_oe_o) |-> ##[1:3] !rst_line_oe_o) else $error("line driven 4 cycles or more");
    a_pin_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        evt.ext_rst && !rst_line_oe_o |=> st_r.state == rsl_pkg::ST_HOLD && !vec_fetch_o)
        else $error("pin reset not held");
    a_init_first: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        vec_fetch_o && cause_o != rsl_pkg::CAUSE_TRAP |-> $past(ctrl_init_we_o)
        && $past(ctrl_init_addr_o) == rsl_pkg::REG_LAST) else $error("fetch before register init");
    a_por_vector: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        vec_fetch_o && cause_o == rsl_pkg::CAUSE_EXT |-> vec_addr_o == rsl_pkg::VEC_POR)
        else $error("wrong start vector");
    a_int_vector: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        vec_fetch_o && cause_o inside {rsl_pkg::CAUSE_WDOG, rsl_pkg::CAUSE_CLKMON}
        |-> vec_addr_o == (cause_o == rsl_pkg::CAUSE_WDOG ? VEC_WDOG : VEC_CLKMON)
        && vec_addr_o != rsl_pkg::VEC_POR)
        else $error("internal reset vector wrong");
    a_trap_noinit: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        cpu_run_o && ill_op_i && !evt.ext_rst && !st_r.clk_fail && !evt.wd_tmo
        |=> !ctrl_init_we_o ##1 vec_fetch_o && vec_addr_o == VEC_TRAP && !rst_line_oe_o)
        else $error("trap path wrong");
    a_sel_locked: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        st_r.win_cnt == rsl_pkg::SEL_WIN_CYC && st_r.state != rsl_pkg::ST_INIT |=> $stable(wd_sel_o))
        else $error("select changed after window");
    a_fail_drive: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (st_r.clk_fail || evt.wd_tmo) && active(st_r.state) && !evt.ext_rst
        |=> rst_line_oe_o && st_r.state == rsl_pkg::ST_DRIVE) else $error("failure did not reset");
    a_irq_wake: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (lp_wait_o || lp_stop_o) && !irq_n_i ##1 !evt.ext_rst && !st_r.clk_fail && !evt.wd_tmo
        |=> cpu_run_o) else $error("interrupt did not wake core");
endmodule // rsl_top
`default_nettype wire

/* File: bench/rsl_line_model.sv */
// far side of the shared reset line: reset switch and the pull-up
`timescale 1ns/1ps
`default_nettype none
module rsl_line_model (
    input  wire logic       clk_i,
    input  wire logic       press_i,
    input  wire logic [7:0] len_i,
    input  wire logic       dev_oe_i,
    input  wire logic       dev_lvl_i,
    output logic            line_n_o
);
    logic [7:0] cnt_r = 8'h00;
    always @(posedge clk_i) begin
        if (press_i) begin
            cnt_r <= len_i;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    // open drain with a pull-up, so a released line reads high, never stale
    assign line_n_o = !((cnt_r != 8'h00) || (dev_oe_i && !dev_lvl_i));
endmodule // rsl_line_model
`default_nettype wire

/* File: bench/rsl_top_bench.sv */
// self-checking testbench of the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
module rsl_top_bench;
    // ----------------------------------------------------------------
    // stimulus, wiring and the blocks
    // ----------------------------------------------------------------
    logic        clk = 1'b0, srst = 1'b1, press = 1'b0, wd_en = 1'b0, sel_wr = 1'b0, sel_hi = 1'b0;
    logic        sel_lo = 1'b0, svc_wr = 1'b0, cm_en = 1'b0, alive = 1'b0, alive_run = 1'b1;
    logic        irq_n = 1'b1, ill = 1'b0, wait_for_interrupt_instruction = 1'b0, stp = 1'b0;
    logic [7:0]  plen = 8'h00, svc_d = 8'h00;
    logic        line_n, oe, lvl, we, fetch, run, lpw, lps, irq_req;
    logic [15:0] iaddr, vaddr;
    logic [1:0]  cause, wsel;
    int          n_mismatch = 0, checks_done = 0, oe_cnt = 0, lo_cnt = 0;

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (alive_run) alive <= ~alive;
        if (oe === 1'b1) oe_cnt++;
        if (line_n === 1'b0) lo_cnt++;
    end

    rsl_line_model i_rsl_line_model (.clk_i(clk), .press_i(press), .len_i(plen), .dev_oe_i(oe),
        .dev_lvl_i(lvl), .line_n_o(line_n));
    rsl_top #(.WD_CYC0(40), .WD_CYC1(80), .WD_CYC2(120), .WD_CYC3(160)) i_rsl_top (
        .sys_clk_i(clk), .srst_i(srst), .rst_line_n_i(line_n), .rst_line_o(lvl), .rst_line_oe_o(oe),
        .wdog_en_i(wd_en), .sel_wr_i(sel_wr), .watchdog_period_select_hi_i(sel_hi),
        .watchdog_period_select_lo_i(sel_lo), .watchdog_service_register_wr_i(svc_wr),
        .watchdog_service_register_data_i(svc_d), .clkmon_en_i(cm_en), .clk_alive_i(alive), .irq_n_i(irq_n),
        .ill_op_i(ill), .wait_for_interrupt_instruction_i(wait_for_interrupt_instruction), .stop_insn_i(stp), .ctrl_init_we_o(we),
        .ctrl_init_addr_o(iaddr), .vec_fetch_o(fetch), .vec_addr_o(vaddr), .cause_o(cause), .cpu_run_o(run),
        .lp_wait_o(lpw), .lp_stop_o(lps), .irq_req_o(irq_req), .wd_sel_o(wsel));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // full init walk, then the vector that the cause selects
    task automatic boot(input logic [15:0] v, input logic [1:0] c);
        int n = 0;
        int k = 0;
        while (we !== 1'b1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        while (we === 1'b1 && n < 200) begin
            chk("init_addr", iaddr, 16'h8000 + 16'(n));
            n++;
            @(posedge clk);
        end
        chk("init_count", 16'(n), 16'h0060);
        chk("fetch", 16'(fetch), 16'h0001);
        chk("vector", vaddr, v);
        chk("cause", 16'(cause), 16'(c));
        @(posedge clk);
        chk("fetch_pulse", 16'(fetch), 16'h0000);
        @(posedge clk);
        chk("run", 16'(run), 16'h0001);
    endtask

    task press_for(input logic [7:0] len);
        @(posedge clk);
        press <= 1'b1;
        plen <= len;
        @(posedge clk);
        press <= 1'b0;
    endtask

    task svc(input logic [7:0] d);
        @(posedge clk);
        svc_wr <= 1'b1;
        svc_d <= d;
        @(posedge clk);
        svc_wr <= 1'b0;
    endtask

    task sel(input logic hi, input logic lo);
        @(posedge clk);
        sel_wr <= 1'b1;
        sel_hi <= hi;
        sel_lo <= lo;
        @(posedge clk);
        sel_wr <= 1'b0;
        @(posedge clk);
    endtask

    // internal reset: short self drive on the line, then the init walk
    task automatic int_rst(input logic [15:0] v, input logic [1:0] c);
        int k = 0;
        while (oe !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        wd_en <= 1'b0;
        cm_en <= 1'b0;
        alive_run <= 1'b1;
        boot(v, c);
        chk("drive_len", 16'(oe_cnt), 16'(rsl_pkg::DRV_CYC));
        chk("line_low_len", 16'(lo_cnt), 16'(rsl_pkg::DRV_CYC));
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_pin;
        int k = 0;
        press_for(8'h04);
        repeat (12) begin
            @(posedge clk);
            if (run !== 1'b1) k++;
        end
        chk("short_low", 16'(k), 16'h0000);
        press_for(8'h05);
        boot(16'hfffe, 2'h0);
        press_for(8'hc8);
        repeat (100) @(posedge clk);
        chk("held_run", 16'(run), 16'h0000);
        boot(16'hfffe, 2'h0);
    endtask

    task automatic t_wdog;
        int k = 0;
        sel(1'b1, 1'b0);
        chk("sel_code2", 16'(wsel), 16'h0002);
        sel(1'b0, 1'b1);
        chk("sel_early", 16'(wsel), 16'h0001);
        repeat (70) @(posedge clk);
        sel(1'b1, 1'b1);
        chk("sel_late", 16'(wsel), 16'h0001);
        wd_en <= 1'b1;
        oe_cnt = 0;
        repeat (4) begin
            repeat (50) @(posedge clk);
            svc(8'h55);
            svc(8'haa);
        end
        chk("serviced", 16'(oe_cnt), 16'h0000);
        lo_cnt = 0;
        // period 80 of select 1, plus the timeout flop and the drive flop
        while (oe !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        chk("wd_period", 16'(k), 16'h0052);
        int_rst(16'he000, 2'h1);
    endtask

    task t_clkmon;
        cm_en <= 1'b1;
        oe_cnt = 0;
        repeat (40) @(posedge clk);
        chk("clock_alive", 16'(oe_cnt), 16'h0000);
        lo_cnt = 0;
        alive_run <= 1'b0;
        int_rst(16'he004, 2'h2);
    endtask

    task automatic t_trap;
        int n = 0;
        int k = 0;
        @(posedge clk);
        ill <= 1'b1;
        @(posedge clk);
        ill <= 1'b0;
        while (fetch !== 1'b1 && k < 6) begin
            @(posedge clk);
            if (we === 1'b1) n++;
            k++;
        end
        chk("trap_init", 16'(n), 16'h0000);
        chk("trap_vec", vaddr, 16'he008);
        chk("trap_cause", 16'(cause), 16'h0003);
        repeat (4) @(posedge clk);
    endtask

    task lp(input logic deep);
        @(posedge clk);
        wait_for_interrupt_instruction <= !deep;
        stp <= deep;
        @(posedge clk);
        wait_for_interrupt_instruction <= 1'b0;
        stp <= 1'b0;
        @(posedge clk);
        chk("lp_wait", 16'(lpw), 16'(!deep));
        chk("lp_stop", 16'(lps), 16'(deep));
        chk("lp_run", 16'(run), 16'h0000);
        irq_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq_req", 16'(irq_req), 16'h0001);
        @(posedge clk);
        chk("wake_run", 16'(run), 16'h0001);
        irq_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        boot(16'hfffe, 2'h0);
        t_pin;
        t_wdog;
        t_clkmon;
        t_trap;
        lp(1'b0);
        lp(1'b1);
        end_of_test;
    end

    // the whole run needs well under two thousand cycles; 20000 means a hang
    initial begin
        #200000;
        n_mismatch++;
        end_of_test;
    end
endmodule // rsl_top_bench
`default_nettype wire
